// ==== logic/seq_consts.svh ====
/*
  Timing constants of the three-rail enable sequencer.
  Assumes a 100 MHz system clock; every count is derived from it.
*/
// Function
// - six separate delay timers, three up, three down
// - rails held low until enable first asserts
// - enable starts timer one, then rail one releases
// - each release starts the next rail's timer
// - enable low runs timers four to six, reverse
// - down delays set apart from up delays
// - enable drop during timer one resets it, rails low
// - interrupted power-up only after timer one done
// - falling enable restarts timer, power-up finishes first
// - power-down starts about 120 ms after last release
// - interrupted power-down only after timer four done
// - rising enable restarts timer, power-down finishes first
// - power-up starts about 120 ms after last low
// - all timers count one common master clock
// - timers one and four add 400 us refresh
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define CLK_MHZ     100
`define TD_UP_US    30000
`define TD_DN_US    30000
`define REFRESH_US  400
`define SETTLE_MS   120

// ----------------------------------------------------------------
// Derived cycle counts
// ----------------------------------------------------------------
`define TD1_CYC     ((`TD_UP_US + `REFRESH_US) * `CLK_MHZ)
`define TD2_CYC     (`TD_UP_US * `CLK_MHZ)
`define TD3_CYC     (`TD_UP_US * `CLK_MHZ)
`define TD4_CYC     ((`TD_DN_US + `REFRESH_US) * `CLK_MHZ)
`define TD5_CYC     (`TD_DN_US * `CLK_MHZ)
`define TD6_CYC     (`TD_DN_US * `CLK_MHZ)
`define SETTLE_CYC  (`SETTLE_MS * 1000 * `CLK_MHZ)

// ----------------------------------------------------------------
// Structure
// ----------------------------------------------------------------
`define NUM_TIMERS  7
`define CNT_W       32

`endif

// ==== logic/seq_pkg.sv ====
/*
  Types of the three-rail enable sequencer.
  Assumes nothing beyond the constants header.
*/
package seq_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_off, st_up1, st_up2, st_up3, st_on,
    st_dn1, st_dn2, st_dn3, st_up_settle, st_dn_settle
  } seq_state_type;

  // ----------------------------------------------------------------
  // Open-drain rail pins: level and active-low enable
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe_n;
  } rail_pins_type;

endpackage : seq_pkg

// ==== logic/delay_timer.sv ====
/*
  One delay timer: counts clock cycles while running.
  Assumes run comes from the sequencer's registered state and clear from its next-state logic.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module delay_timer (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              run,
  input  wire logic              clear,
  input  wire logic [`CNT_W-1:0] limit,
  output logic                   done
);

  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;

  // Next count; clear wins so a restart always begins at zero
  always_comb begin
    next_cnt = cnt;
    if (clear) begin
      next_cnt = '0;
    end else if (run) begin
      next_cnt = cnt + `CNT_W'(1);
    end
  end

  // Counter register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Terminal count, a period of exactly limit cycles
  assign done = run && (cnt == limit - `CNT_W'(1));

endmodule : delay_timer

// ==== logic/three_rail_enable_sequencer.sv ====
/*
  Three-rail enable sequencer: releases three open-drain rail enables
  in order 1-2-3 and pulls them low in order 3-2-1 under one enable.
  Assumes enable is synchronous to sys_clk and driven by digital logic.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module three_rail_enable_sequencer #(
  parameter int unsigned TD1_CYCLES    = `TD1_CYC,
  parameter int unsigned TD2_CYCLES    = `TD2_CYC,
  parameter int unsigned TD3_CYCLES    = `TD3_CYC,
  parameter int unsigned TD4_CYCLES    = `TD4_CYC,
  parameter int unsigned TD5_CYCLES    = `TD5_CYC,
  parameter int unsigned TD6_CYCLES    = `TD6_CYC,
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               en,
  output seq_pkg::rail_pins_type  rails
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_pkg::seq_state_type  state;
  seq_pkg::seq_state_type  next_state;
  logic                    pend_down;
  logic                    next_pend_down;
  logic                    pend_up;
  logic                    next_pend_up;
  logic                    en_q;
  logic                    en_rise;
  logic                    en_fall;
  logic                    restart;
  logic                    clear;
  logic [2:0]              released;
  logic [2:0]              next_released;
  logic [`NUM_TIMERS-1:0]  run;
  logic [`NUM_TIMERS-1:0]  done;
  logic [`CNT_W-1:0]       limit [`NUM_TIMERS];
  logic [`CNT_W-1:0]       dwell;
  logic [`CNT_W-1:0]       next_dwell;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------

  // Limits; up and down periods are separate parameters
  assign limit[0] = `CNT_W'(TD1_CYCLES);
  assign limit[1] = `CNT_W'(TD2_CYCLES);
  assign limit[2] = `CNT_W'(TD3_CYCLES);
  assign limit[3] = `CNT_W'(TD4_CYCLES);
  assign limit[4] = `CNT_W'(TD5_CYCLES);
  assign limit[5] = `CNT_W'(TD6_CYCLES);
  assign limit[6] = `CNT_W'(SETTLE_CYCLES);

  // Each sequence timer runs only in its own state; the settle timer in both settle states
  assign run[0] = (state == seq_pkg::st_up1);
  assign run[1] = (state == seq_pkg::st_up2);
  assign run[2] = (state == seq_pkg::st_up3);
  assign run[3] = (state == seq_pkg::st_dn1);
  assign run[4] = (state == seq_pkg::st_dn2);
  assign run[5] = (state == seq_pkg::st_dn3);
  assign run[6] = (state == seq_pkg::st_up_settle) ||
                  (state == seq_pkg::st_dn_settle);

  // Any move or edge restart zeroes the counts for the next state
  assign clear = restart || (next_state != state);

  // Six sequence timers plus the settle timer, all on sys_clk
  for (genvar i = 0; i < `NUM_TIMERS; i++) begin : g_timer
    delay_timer u_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .run     (run[i]),
      .clear   (clear),
      .limit   (limit[i]),
      .done    (done[i])
    );
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign en_rise = en && !en_q;
  assign en_fall = !en && en_q;

  // Next state; an edge restart has priority over a timer expiry
  always_comb begin
    next_state     = state;
    next_pend_down = pend_down;
    next_pend_up   = pend_up;
    restart        = 1'b0;
    unique case (state)
      seq_pkg::st_off: begin
        if (en) next_state = seq_pkg::st_up1;
      end
      seq_pkg::st_up1: begin
        if (!en) begin
          next_state = seq_pkg::st_off;
        end else if (done[0]) begin
          next_state = seq_pkg::st_up2;
        end
      end
      seq_pkg::st_up2: begin
        if (en_fall) begin
          restart        = 1'b1;
          next_pend_down = 1'b1;
        end else if (done[1]) begin
          next_state = seq_pkg::st_up3;
        end
      end
      seq_pkg::st_up3: begin
        if (en_fall) begin
          restart        = 1'b1;
          next_pend_down = 1'b1;
        end else if (done[2]) begin
          next_pend_down = 1'b0;
          next_state     = pend_down ? seq_pkg::st_up_settle
                                     : seq_pkg::st_on;
        end
      end
      seq_pkg::st_on: begin
        if (!en) next_state = seq_pkg::st_dn1;
      end
      seq_pkg::st_dn1: begin
        if (en) begin
          next_state = seq_pkg::st_on;
        end else if (done[3]) begin
          next_state = seq_pkg::st_dn2;
        end
      end
      seq_pkg::st_dn2: begin
        if (en_rise) begin
          restart      = 1'b1;
          next_pend_up = 1'b1;
        end else if (done[4]) begin
          next_state = seq_pkg::st_dn3;
        end
      end
      seq_pkg::st_dn3: begin
        if (en_rise) begin
          restart      = 1'b1;
          next_pend_up = 1'b1;
        end else if (done[5]) begin
          next_pend_up = 1'b0;
          next_state   = pend_up ? seq_pkg::st_dn_settle
                                 : seq_pkg::st_off;
        end
      end
      seq_pkg::st_up_settle: begin
        // Enable may have come back meanwhile; then stay powered
        if (done[6]) begin
          next_state = en ? seq_pkg::st_on : seq_pkg::st_dn1;
        end
      end
      seq_pkg::st_dn_settle: begin
        if (done[6]) begin
          next_state = en ? seq_pkg::st_up1 : seq_pkg::st_off;
        end
      end
    endcase
  end

  // Rail release pattern follows the next state
  always_comb begin
    unique case (next_state)
      seq_pkg::st_up2, seq_pkg::st_dn3: next_released = 3'h1;
      seq_pkg::st_up3, seq_pkg::st_dn2: next_released = 3'h3;
      seq_pkg::st_on, seq_pkg::st_dn1,
      seq_pkg::st_up_settle:            next_released = 3'h7;
      default:                          next_released = 3'h0;
    endcase
  end

  // State registers; reset holds every rail low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= seq_pkg::st_off;
      pend_down <= 1'b0;
      pend_up   <= 1'b0;
      en_q      <= 1'b0;
      released  <= 3'h0;
    end else begin
      state     <= next_state;
      pend_down <= next_pend_down;
      pend_up   <= next_pend_up;
      en_q      <= en;
      released  <= next_released;
    end
  end

  // Open drain: level is always low, a released rail stops driving
  assign rails.level = 3'h0;
  assign rails.oe_n  = released;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Helper: cycles since the last timer clear, restarts with the timers
  always_comb begin
    next_dwell = clear ? '0 : dwell + `CNT_W'(1);
  end

  // Helper register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dwell <= '0;
    end else begin
      dwell <= next_dwell;
    end
  end

  sequence s_glitch;
    (state == seq_pkg::st_up1) ##0 !en;
  endsequence

  sequence s_down_edge;
    ((state == seq_pkg::st_up2) || (state == seq_pkg::st_up3)) ##0 en_fall;
  endsequence

  a_off_held_low: assert property (
    (state == seq_pkg::st_off) |-> (rails.oe_n == 3'h0))
    else $error("rail released while off");

  a_glitch_reset: assert property (
    s_glitch |=> (state == seq_pkg::st_off) && (rails.oe_n == 3'h0)
                 && (dwell == '0))
    else $error("enable glitch not filtered");

  a_first_delay: assert property (
    $rose(rails.oe_n[0]) |-> $past(dwell) == limit[0] - `CNT_W'(1))
    else $error("first rail released at wrong time");

  a_up_order: assert property (
    ($rose(rails.oe_n[1]) |-> rails.oe_n[0] && $past(rails.oe_n[0])) and
    ($rose(rails.oe_n[2]) |-> $past(dwell) == limit[2] - `CNT_W'(1)))
    else $error("power-up order or delay wrong");

  a_down_order: assert property (
    ($fell(rails.oe_n[2]) |-> $past(dwell) == limit[3] - `CNT_W'(1)) and
    ($fell(rails.oe_n[0]) |-> !rails.oe_n[1] && !$past(rails.oe_n[1])))
    else $error("power-down order or delay wrong");

  a_up_restart: assert property (
    s_down_edge |=> (dwell == '0) && pend_down && $stable(rails.oe_n))
    else $error("power-up timer not restarted");

  a_no_early_down: assert property (
    pend_down |-> !$fell(rails.oe_n[2]) && !$fell(rails.oe_n[1]))
    else $error("rail dropped during unfinished power-up");

  a_settle_down: assert property (
    ($past(state) == seq_pkg::st_up_settle) &&
    (state == seq_pkg::st_dn1) |-> $past(dwell) == limit[6] - `CNT_W'(1))
    else $error("settle before power-down wrong");

  a_down_restart: assert property (
    ((state == seq_pkg::st_dn2) || (state == seq_pkg::st_dn3)) && en_rise
    |=> (dwell == '0) && pend_up && (state == $past(state)))
    else $error("power-down timer not restarted");

  a_settle_up: assert property (
    ($past(state) == seq_pkg::st_dn_settle) &&
    (state == seq_pkg::st_up1) |-> rails.oe_n == 3'h0 &&
    $past(dwell) == limit[6] - `CNT_W'(1))
    else $error("settle before power-up wrong");

  a_dn_glitch: assert property (
    (state == seq_pkg::st_dn1) && en |=>
    (state == seq_pkg::st_on) && (rails.oe_n == 3'h7))
    else $error("power-down glitch not filtered");

endmodule : three_rail_enable_sequencer

// ==== test/rail_pullup_model.sv ====
/*
  Pull-up model of the regulator enable inputs on the three rails.
  Assumes the sequencer drives its rails as open-drain pins.
*/
`timescale 1ns/1ps

module rail_pullup_model (
  input  seq_pkg::rail_pins_type rails,
  output logic [2:0]             rail_on
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Released pin goes to the pull-up; a driven pin shows its level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rail_on[i] = rails.oe_n[i] ? 1'h1 : rails.level[i];
    end
  end
endmodule : rail_pullup_model

// ==== test/three_rail_enable_sequencer_tb_top.sv ====
/*
  Self-checking bench of the three-rail enable sequencer.
  Assumes short timer parameters and the pull-up model on the rails.
*/
`timescale 1ns/1ps

module three_rail_enable_sequencer_tb_top;
  localparam int TD1 = 5;
  localparam int TD2 = 7;
  localparam int TD3 = 9;
  localparam int TD4 = 6;
  localparam int TD5 = 8;
  localparam int TD6 = 10;
  localparam int ST  = 30;

  typedef struct {
    logic [2:0] v;
    int         at;
    int         gap;
    int         slack;
  } note_type;

  logic                   sys_clk;
  logic                   nrst;
  logic                   en;
  seq_pkg::rail_pins_type rails;
  logic [2:0]             rail_on;
  logic [2:0]             prev = 3'h0;
  logic [16:0]            lfsr_state;
  int                     cyc = 0;
  int                     last = 0;
  int                     mismatches;
  int                     checks;
  note_type               notes[$];

  three_rail_enable_sequencer #(
    .TD1_CYCLES(TD1), .TD2_CYCLES(TD2), .TD3_CYCLES(TD3),
    .TD4_CYCLES(TD4), .TD5_CYCLES(TD5), .TD6_CYCLES(TD6),
    .SETTLE_CYCLES(ST)
  ) u_dut (
    .sys_clk(sys_clk),
    .nrst   (nrst),
    .en     (en),
    .rails  (rails)
  );

  rail_pullup_model u_pullup (
    .rails  (rails),
    .rail_on(rail_on)
  );

  // ----------------------------------------------------------------
  // Clock, edge count and helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  // Returns 1..span from the shift register
  function automatic int rnd(int span);
    lfsr_state = {lfsr_state[15:0], lfsr_state[16] ^ lfsr_state[13]};
    return 1 + int'(lfsr_state) % span;
  endfunction : rnd

  task automatic check_level(string what, logic [2:0] exp,
                             logic [2:0] seen);
    checks++;
    if (exp !== seen) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_level

  task automatic check_time(string what, int exp, int seen, int slack);
    checks++;
    if (seen < exp - slack || seen > exp + slack) begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check_time

  task automatic wrap_up();
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic idle(int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle

  // Gap > 0: cycles after the previous change, else absolute edge
  task automatic expect_step(logic [2:0] v, int at, int gap, int slack);
    notes.push_back('{v, at, gap, slack});
  endtask : expect_step

  // Bounded so a dead sequencer cannot stall the driver
  task automatic wait_level(logic [2:0] v);
    int n;
    n = 0;
    while (rail_on !== v && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_level

  // Pulse of 1 to td cycles, no longer than the first timer of that direction
  task automatic glitch(logic lvl, int td);
    int n;
    n = rnd(td);
    en = lvl;
    idle(n);
    en = ~lvl;
    idle(td + 4);
  endtask : glitch

  task automatic power_up();
    en = 1'h1;
    // Enable is sampled at the next edge; release follows TD1 later
    expect_step(3'h1, cyc + 1 + TD1, 0, 0);
    expect_step(3'h3, 0, TD2, 0);
    expect_step(3'h7, 0, TD3, 0);
    wait_level(3'h7);
    idle(3);
  endtask : power_up

  task automatic power_down();
    en = 1'h0;
    expect_step(3'h3, cyc + 1 + TD4, 0, 0);
    expect_step(3'h1, 0, TD5, 0);
    expect_step(3'h0, 0, TD6, 0);
    wait_level(3'h0);
    idle(3);
  endtask : power_down

  // ----------------------------------------------------------------
  // Output watcher: every rail change must match the oldest note
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin : watch
    note_type t;
    #1;
    if (nrst && rail_on !== prev) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("ERROR rails expected %b seen %b", prev, rail_on);
      end else begin
        t = notes.pop_front();
        check_level("rails", t.v, rail_on);
        check_time("step edge", (t.gap > 0) ? last + t.gap : t.at,
                   cyc, t.slack);
      end
      last = cyc;
      prev = rail_on;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    en         = 1'h0;
    nrst       = 1'h0;
    mismatches = 0;
    checks     = 0;
    lfsr_state = 17'h167B7;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'h1;
    check_level("rails after reset", 3'h0, rail_on);
    idle(10);
    repeat (3) glitch(1'h1, TD1);
    power_up();
    repeat (3) glitch(1'h0, TD4);
    power_down();
    // Enable drops inside timer two: finish, settle, then go down
    en = 1'h1;
    expect_step(3'h1, cyc + 1 + TD1, 0, 0);
    wait_level(3'h1);
    idle(rnd(TD2 - 2));
    en = 1'h0;
    // Falling edge seen at the next edge restarts timer two there
    expect_step(3'h3, cyc + 1 + TD2, 0, 0);
    expect_step(3'h7, 0, TD3, 0);
    expect_step(3'h3, 0, ST + TD4, 0);
    expect_step(3'h1, 0, TD5, 0);
    expect_step(3'h0, 0, TD6, 0);
    wait_level(3'h0);
    idle(3);
    // Enable returns inside timer five: finish, settle, then go up
    power_up();
    en = 1'h0;
    expect_step(3'h3, cyc + 1 + TD4, 0, 0);
    wait_level(3'h3);
    idle(rnd(TD5 - 2));
    en = 1'h1;
    expect_step(3'h1, cyc + 1 + TD5, 0, 0);
    expect_step(3'h0, 0, TD6, 0);
    expect_step(3'h1, 0, ST + TD1, 0);
    expect_step(3'h3, 0, TD2, 0);
    expect_step(3'h7, 0, TD3, 0);
    wait_level(3'h7);
    idle(20);
    check_time("pending steps", 0, notes.size(), 0);
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule : three_rail_enable_sequencer_tb_top
